// >>> rtl/pcs_cmd_status.sv
/*
 * Command and status registers of a PCI function, with the gating that the
 * command bits apply to target claims, master requests and the system error
 * line, and the hardware-set status flags. Assumes the bus interface decodes
 * configuration cycles into single-cycle read and write strobes on clk, and
 * reports its own events as single-cycle pulses on the same clock.
 */
module pcs_cmd_status
	import pcs_pkg::*;
#(
	parameter bit MASTER_CAPABLE = 1'b1
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_done,
	input wire logic io_hit,
	input wire logic mem_hit,
	input wire logic mst_req,
	input wire logic mwi_req,
	input wire logic serr_req,
	input wire logic tgt_abort_ev,
	input wire logic perr_det_ev,
	input wire logic mst_dperr_ev,
	input wire logic mst_rx_tabort_ev,
	input wire logic mst_rx_mabort_ev,
	output logic io_claim,
	output logic mem_claim,
	output logic mst_grant_ok,
	output logic mwi_ok,
	output logic perr_report_en,
	output logic serr_o,
	output logic serr_oe,
	output logic func_disabled
);

	localparam logic [15:0] CMD_WMASK = MASTER_CAPABLE ? PCS_CMD_WMASK_MST : PCS_CMD_WMASK_TGT;
	localparam logic [15:0] STAT_MASK = MASTER_CAPABLE ? PCS_STAT_W1C_MST : PCS_STAT_W1C_TGT;
	// Completion latency, held locally so the check below can use it as a plain delay.
	localparam int CFG_LAT = PCS_CFG_LATENCY;

	logic [15:0] command;
	logic [15:0] flags;
	logic [15:0] status;
	logic [15:0] stat_fixed;
	logic [15:0] stat_set;
	logic [15:0] stat_clr;
	logic hit;
	logic cmd_we;

	////////////////////////////////////////////////////////////////////////////
	// Configuration access decode

	// Only the command/status dword is mapped here; every other offset is
	// answered with zero so the bus never hangs on a reserved location.
	assign hit = cfg_addr[7:2] == PCS_CMD_STAT_OFS[7:2];
	assign cmd_we = cfg_wr && hit && (cfg_be[1:0] != 2'h0);

	pcs_cmd_reg #(
		.WMASK(CMD_WMASK)
	) u_cmd (
		.clk(clk),
		.reset_n(reset_n),
		.we(cmd_we),
		.be(cfg_be[1:0]),
		.wdata(cfg_wdata[15:0]),
		.command(command)
	);

	////////////////////////////////////////////////////////////////////////////
	// Status flags

	// Each flag is set by its own hardware event only.
	always_comb begin
		stat_set = 16'h0000;
		stat_set[PCS_ST_DPD] = mst_dperr_ev && command[PCS_CMD_PERR];
		stat_set[PCS_ST_STA] = tgt_abort_ev;
		stat_set[PCS_ST_RTA] = mst_rx_tabort_ev;
		stat_set[PCS_ST_RMA] = mst_rx_mabort_ev;
		stat_set[PCS_ST_SSE] = serr_oe;
		stat_set[PCS_ST_DPE] = perr_det_ev;
	end

	// Writes to the status half only ever clear; ones in read-only places vanish.
	always_comb begin
		stat_clr = 16'h0000;
		if (cfg_wr && hit) begin
			stat_clr[7:0] = cfg_be[2] ? cfg_wdata[23:16] : 8'h00;
			stat_clr[15:8] = cfg_be[3] ? cfg_wdata[31:24] : 8'h00;
		end
	end

	pcs_w1c_flags #(
		.MASK(STAT_MASK)
	) u_flags (
		.clk(clk),
		.reset_n(reset_n),
		.set(stat_set),
		.clr(stat_clr),
		.flags(flags)
	);

	// Capability list present; 66 MHz, user-definable features and fast back-to-back stay zero.
	always_comb begin
		stat_fixed = 16'h0000;
		stat_fixed[PCS_ST_CAP] = 1'b1;
		stat_fixed[PCS_ST_DEVSEL +: 2] = PCS_DEVSEL_TIMING;
	end

	assign status = (flags | stat_fixed) & ~PCS_STAT_NOSUP;

	////////////////////////////////////////////////////////////////////////////
	// Read data and completion

	// Reads return one cycle later; unmapped offsets return zero.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_rdata <= 32'h00000000;
		end else if (cfg_rd) begin
			cfg_rdata <= hit ? {status, command} : 32'h00000000;
		end
	end

	// Every access completes, mapped or not, so configuration stays reachable.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg_done <= 1'b0;
		end else begin
			cfg_done <= cfg_rd || cfg_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gating of target claims

	// A clear enable blocks the claim; this is what makes an all-zero command
	// disconnect the function while leaving configuration untouched.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			io_claim <= 1'b0;
			mem_claim <= 1'b0;
		end else begin
			io_claim <= io_hit && command[PCS_CMD_IO];
			mem_claim <= mem_hit && command[PCS_CMD_MEM];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Gating of master requests

	// The target-only variant never stores bit 2, so it never grants.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mst_grant_ok <= 1'b0;
			mwi_ok <= 1'b0;
		end else begin
			mst_grant_ok <= mst_req && command[PCS_CMD_MST];
			mwi_ok <= mwi_req && command[PCS_CMD_MST] && command[PCS_CMD_MWI];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Parity reporting and system error line

	// The error line is open drain: it is only ever pulled low.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			perr_report_en <= 1'b0;
			serr_o <= 1'b0;
			serr_oe <= 1'b0;
		end else begin
			perr_report_en <= command[PCS_CMD_PERR];
			serr_o <= 1'b0;
			serr_oe <= serr_req && command[PCS_CMD_SERR];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Disconnect indication

	// Lets the bus logic idle every engine at once when command is zero.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			func_disabled <= 1'b1;
		end else begin
			func_disabled <= command == 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!reset_n);

	// A full write of the command half, and a write of one to the abort flag with no abort event.
	sequence s_cmd_write_full;
		cfg_wr && hit && cfg_be[1:0] == 2'h3;
	endsequence

	sequence s_sta_clear_write;
		cfg_wr && hit && cfg_be[3] && cfg_wdata[16 + PCS_ST_STA] && !tgt_abort_ev;
	endsequence

	cmd_zero_quiet_a: assert property (
		command == 16'h0000 |=> !io_claim && !mem_claim && !mst_grant_ok && !mwi_ok && !serr_oe && func_disabled)
		else $error("function not quiet with zero command");

	reset_disabled_a: assert property (disable iff (1'b0)
		!reset_n |=> command == 16'h0000 && !io_claim && !mem_claim && !mst_grant_ok)
		else $error("function enabled after reset");

	io_gate_a: assert property (
		1'b1 |=> io_claim == $past(io_hit && command[PCS_CMD_IO]))
		else $error("io claim not gated by command bit 0");

	mem_gate_a: assert property (
		mem_hit && !command[PCS_CMD_MEM] |=> !mem_claim)
		else $error("memory claim while memory space disabled");

	mwi_gate_a: assert property (
		mwi_ok |-> $past(command[PCS_CMD_MWI]))
		else $error("invalidate write permitted with bit 4 clear");

	serr_gate_a: assert property (
		serr_oe |-> $past(command[PCS_CMD_SERR]) && $past(serr_req))
		else $error("error line driven without enable");

	unimpl_bits_a: assert property (
		s_cmd_write_full |=> (command & PCS_CMD_UNIMPL) == 16'h0000)
		else $error("unimplemented command bit stored");

	stat_reset_a: assert property (disable iff (1'b0)
		!reset_n |=> flags == 16'h0000)
		else $error("status flags not cleared by reset");

	no_sw_set_a: assert property (
		$rose(flags[PCS_ST_STA]) |-> $past(tgt_abort_ev))
		else $error("abort flag set without event");

	w1c_clear_a: assert property (
		s_sta_clear_write |=> !flags[PCS_ST_STA])
		else $error("write of one did not clear flag");

	cap_bit_a: assert property (
		cfg_rd && hit |=> cfg_rdata[16 + PCS_ST_CAP] && cfg_done)
		else $error("capabilities bit not reading one");

	no_support_a: assert property (
		cfg_rd && hit |=> cfg_rdata[23:21] == 3'h0)
		else $error("unsupported capability reported");

	sta_set_a: assert property (
		tgt_abort_ev |=> flags[PCS_ST_STA])
		else $error("target abort not recorded");

	sse_set_a: assert property (
		serr_oe |=> flags[PCS_ST_SSE] ##1 flags[PCS_ST_SSE] || $past(stat_clr[PCS_ST_SSE]))
		else $error("system error assertion not recorded");

	dpe_set_a: assert property (
		perr_det_ev && !command[PCS_CMD_PERR] |=> flags[PCS_ST_DPE])
		else $error("parity error not recorded");

	dpd_gate_a: assert property (
		mst_dperr_ev && !command[PCS_CMD_PERR] && !flags[PCS_ST_DPD] |=> !flags[PCS_ST_DPD])
		else $error("data parity flag set with response disabled");

	mabort_variant_a: assert property (
		mst_rx_tabort_ev && mst_rx_mabort_ev |=>
			flags[PCS_ST_RTA] == MASTER_CAPABLE && flags[PCS_ST_RMA] == MASTER_CAPABLE)
		else $error("abort flags wrong for this variant");

	unmapped_read_a: assert property (
		cfg_rd && !hit |=> cfg_done && cfg_rdata == 32'h00000000)
		else $error("unmapped read not zero");

	ro_write_a: assert property (
		cfg_wr && !hit |=> cfg_done && $stable(command))
		else $error("write outside map changed command");

	done_latency_a: assert property (
		cfg_rd || cfg_wr |-> ##CFG_LAT cfg_done)
		else $error("access not completed in time");

	done_cause_a: assert property (
		cfg_done |-> $past(cfg_rd || cfg_wr))
		else $error("completion without an access");

	perr_gate_a: assert property (
		1'b1 |=> perr_report_en == $past(command[PCS_CMD_PERR]))
		else $error("parity reporting not following bit 6");

	mst_gate_a: assert property (
		mst_req && !command[PCS_CMD_MST] |=> !mst_grant_ok && !mwi_ok)
		else $error("master activity with bit 2 clear");

	cmd_live_a: assert property (
		command != 16'h0000 |=> !func_disabled)
		else $error("function disabled with nonzero command");

endmodule

// >>> rtl/pcs_pkg.sv
/*
 * Constants for the command and status registers of a PCI function's
 * configuration header: offsets, bit positions, write masks and reset values.
 * Assumes the configuration decoder of the bus interface presents byte
 * addresses within the 256-byte configuration space of this function.
 */
package pcs_pkg;

	// Byte offset of the dword holding command (low half) and status (high half).
	localparam logic [7:0] PCS_CMD_STAT_OFS = 8'h04;

	// Command register bit positions.
	localparam int PCS_CMD_IO = 0;
	localparam int PCS_CMD_MEM = 1;
	localparam int PCS_CMD_MST = 2;
	localparam int PCS_CMD_MWI = 4;
	localparam int PCS_CMD_PERR = 6;
	localparam int PCS_CMD_SERR = 8;

	// Status register bit positions.
	localparam int PCS_ST_CAP = 4;
	localparam int PCS_ST_DPD = 8;
	localparam int PCS_ST_DEVSEL = 9;
	localparam int PCS_ST_STA = 11;
	localparam int PCS_ST_RTA = 12;
	localparam int PCS_ST_RMA = 13;
	localparam int PCS_ST_SSE = 14;
	localparam int PCS_ST_DPE = 15;

	// Values after reset.
	localparam logic [15:0] PCS_CMD_RESET = 16'h0000;
	localparam logic [15:0] PCS_STAT_RESET = 16'h0000;

	// Writable command bits for the master-capable and target-only variants.
	localparam logic [15:0] PCS_CMD_WMASK_MST = 16'h0157;
	localparam logic [15:0] PCS_CMD_WMASK_TGT = 16'h0153;
	// Command bits that are never implemented.
	localparam logic [15:0] PCS_CMD_UNIMPL = 16'h02a8;

	// Write-one-to-clear status flags for each variant.
	localparam logic [15:0] PCS_STAT_W1C_MST = 16'hf900;
	localparam logic [15:0] PCS_STAT_W1C_TGT = 16'hc900;
	// Capability bits that read as zero.
	localparam logic [15:0] PCS_STAT_NOSUP = 16'h00e0;

	// Fixed device-select decode timing reported in status bits 9-10.
	localparam logic [1:0] PCS_DEVSEL_TIMING = 2'h1;

	// Cycles from a taken configuration request to its completion pulse.
	localparam int PCS_CFG_LATENCY = 1;

endpackage

// >>> rtl/pcs_cmd_reg.sv
/*
 * Command register storage with per-byte write enables and a mask of the
 * bits that are implemented. Assumes the caller has already decoded the
 * register's address; write strobes come from logic on the same clock.
 */
module pcs_cmd_reg
	import pcs_pkg::*;
#(
	parameter logic [15:0] WMASK = PCS_CMD_WMASK_MST
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [15:0] wdata,
	output logic [15:0] command
);

	// Masked bits take zero on a write, so unimplemented controls stay clear.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			command <= PCS_CMD_RESET;
		end else if (we) begin
			if (be[0]) begin
				command[7:0] <= wdata[7:0] & WMASK[7:0];
			end
			if (be[1]) begin
				command[15:8] <= wdata[15:8] & WMASK[15:8];
			end
		end
	end

endmodule

// >>> rtl/pcs_w1c_flags.sv
/*
 * Status flags that hardware sets and software clears by writing one.
 * Assumes set and clear vectors are single-cycle terms on the same clock.
 */
module pcs_w1c_flags
	import pcs_pkg::*;
#(
	parameter logic [15:0] MASK = PCS_STAT_W1C_MST
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [15:0] set,
	input wire logic [15:0] clr,
	output logic [15:0] flags
);

	// One flop per implemented bit; set beats clear so no event is lost.
	for (genvar i = 0; i < 16; i++) begin : g_bit
		if (MASK[i]) begin : g_impl
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					flags[i] <= PCS_STAT_RESET[i];
				end else if (set[i]) begin
					flags[i] <= 1'b1;
				end else if (clr[i]) begin
					flags[i] <= 1'b0;
				end
			end
		end else begin : g_none
			assign flags[i] = 1'b0;
		end
	end

endmodule

// >>> testbench/pcs_host_model.sv
/*
 * Behavioural host that issues configuration cycles to the command and status dword.
 * Assumes the design takes a strobe at a rising edge and pulses cfg_done right after that edge.
 */
module pcs_host_model (
	input wire logic clk,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_done
);
	timeunit 1ns;
	timeprecision 100ps;

	////////////////////////////////////////////////////////////////////////////////
	// The bus starts idle at time zero.
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end

	// One access: the strobe stands for a single cycle, and the answer is taken just after the taking edge.
	// Released address, enable and data lines show the inverse of their last value, so a design that samples them late sees garbage.
	// Clearing a flag is done by writing one to its bit in the status half.
	task automatic access(input logic wr, input logic rd, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] data, output logic [31:0] rdata, output logic ok);
		@(posedge clk);
		#1;
		cfg_wr = wr;
		cfg_rd = rd;
		cfg_addr = addr;
		cfg_be = be;
		cfg_wdata = data;
		@(posedge clk);
		#1;
		ok = cfg_done;
		rdata = cfg_rdata;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = ~addr;
		cfg_be = ~be;
		cfg_wdata = ~data;
	endtask
endmodule

// >>> testbench/pcs_cmd_status_tb.sv
/*
 * Self-checking bench for the command and status registers: reset values, enables,
 * gating, hardware-set flags, write-one-to-clear, unmapped accesses and a mid-run reset.
 * Runs the master-capable variant and, on the same stimulus, the target-only one.
 * Assumes the host model in pcs_host_model.sv.
 */
module pcs_cmd_status_tb
	import pcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] ST_FIX = (16'(PCS_DEVSEL_TIMING) << PCS_ST_DEVSEL) | (16'h1 << PCS_ST_CAP);
	localparam logic [7:0] OFS = PCS_CMD_STAT_OFS;
	// Bits that only the master-capable variant implements read zero in the target-only one.
	localparam logic [31:0] TGT_KEEP = ~{PCS_STAT_W1C_MST & ~PCS_STAT_W1C_TGT, PCS_CMD_WMASK_MST & ~PCS_CMD_WMASK_TGT};

	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic io_hit = 1'b0, mem_hit = 1'b0, mst_req = 1'b0, mwi_req = 1'b0, serr_req = 1'b0;
	logic tgt_abort_ev = 1'b0, perr_det_ev = 1'b0, mst_dperr_ev = 1'b0;
	logic mst_rx_tabort_ev = 1'b0, mst_rx_mabort_ev = 1'b0;
	logic cfg_wr, cfg_rd, cfg_done, ok;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, rdat;
	logic [31:0] t_rdata;
	logic t_done, t_grant, t_mwi;
	logic io_claim, mem_claim, mst_grant_ok, mwi_ok, perr_report_en, serr_o, serr_oe, func_disabled;
	int num_errors = 0;
	int n_tests = 0;

	////////////////////////////////////////////////////////////////////////////////
	// The 50 MHz clock.
	always #10 clk = ~clk;

	pcs_cmd_status #(.MASTER_CAPABLE(1'b1)) pcs_cmd_status_inst (.clk(clk), .reset_n(reset_n),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_done(cfg_done), .io_hit(io_hit), .mem_hit(mem_hit), .mst_req(mst_req),
		.mwi_req(mwi_req), .serr_req(serr_req), .tgt_abort_ev(tgt_abort_ev), .perr_det_ev(perr_det_ev),
		.mst_dperr_ev(mst_dperr_ev), .mst_rx_tabort_ev(mst_rx_tabort_ev), .mst_rx_mabort_ev(mst_rx_mabort_ev),
		.io_claim(io_claim), .mem_claim(mem_claim), .mst_grant_ok(mst_grant_ok), .mwi_ok(mwi_ok),
		.perr_report_en(perr_report_en), .serr_o(serr_o), .serr_oe(serr_oe), .func_disabled(func_disabled));

	// Target-only variant on the same stimulus; its reads and master gating are compared.
	pcs_cmd_status #(.MASTER_CAPABLE(1'b0)) pcs_cmd_status_tgt_inst (.clk(clk), .reset_n(reset_n),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(t_rdata), .cfg_done(t_done), .io_hit(io_hit), .mem_hit(mem_hit), .mst_req(mst_req),
		.mwi_req(mwi_req), .serr_req(serr_req), .tgt_abort_ev(tgt_abort_ev), .perr_det_ev(perr_det_ev),
		.mst_dperr_ev(mst_dperr_ev), .mst_rx_tabort_ev(mst_rx_tabort_ev), .mst_rx_mabort_ev(mst_rx_mabort_ev),
		.io_claim(), .mem_claim(), .mst_grant_ok(t_grant), .mwi_ok(t_mwi),
		.perr_report_en(), .serr_o(), .serr_oe(), .func_disabled());

	pcs_host_model pcs_host_model_inst (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_done(cfg_done));

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, bus and event helpers.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		pcs_host_model_inst.access(1'b1, 1'b0, a, be, d, rdat, ok);
		chk("write done", 32'h1, {31'h0, ok});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		pcs_host_model_inst.access(1'b0, 1'b1, a, 4'hf, 32'h0, rdat, ok);
		chk("read done", 32'h1, {31'h0, ok});
		chk("read data", exp, rdat);
		chk("target read done", 32'h1, {31'h0, t_done});
		chk("target read data", exp & TGT_KEEP, t_rdata);
	endtask

	// Gating outputs are compared as one byte; callers let two edges pass after any input change.
	task automatic outs(input logic [7:0] exp);
		chk("gate outputs", {24'h0, exp}, {24'h0, io_claim, mem_claim, mst_grant_ok, mwi_ok,
			perr_report_en, serr_o, serr_oe, func_disabled});
		chk("target master gating", 32'h0, {30'h0, t_grant, t_mwi});
	endtask

	task automatic ev(input logic [4:0] v);
		@(posedge clk);
		#1;
		{tgt_abort_ev, perr_det_ev, mst_dperr_ev, mst_rx_tabort_ev, mst_rx_mabort_ev} = v;
		@(posedge clk);
		#1;
		{tgt_abort_ev, perr_det_ev, mst_dperr_ev, mst_rx_tabort_ev, mst_rx_mabort_ev} = 5'h00;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence. Hits and requests stay high, serr_req aside while flags are read and cleared, so that every enable is seen gating them.
	initial begin
		repeat (10) @(posedge clk);
		#1;
		reset_n = 1'b1;
		{io_hit, mem_hit, mst_req, mwi_req, serr_req} = 5'h1f;
		rd(OFS, {ST_FIX, 16'h0000});
		outs(8'h01);
		wr(OFS, 4'hf, 32'hffffffff);
		rd(OFS, {ST_FIX, PCS_CMD_WMASK_MST});
		outs(8'hfa);
		ev(5'h1f);
		serr_req = 1'b0;
		rd(OFS, {ST_FIX | PCS_STAT_W1C_MST, PCS_CMD_WMASK_MST});
		wr(OFS, 4'hc, 32'h08000000);
		rd(OFS, {ST_FIX | 16'hf100, PCS_CMD_WMASK_MST});
		wr(OFS, 4'hc, 32'h00000000);
		wr(OFS, 4'h3, 32'h00000000);
		rd(OFS, {ST_FIX | 16'hf100, 16'h0000});
		serr_req = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		outs(8'h01);
		wr(OFS, 4'hc, 32'hffff0000);
		ev(5'h0c);
		rd(OFS, {ST_FIX | 16'h8000, 16'h0000});
		// Only the low byte is enabled, so the upper command byte must stay clear.
		wr(OFS, 4'h1, 32'h0000ffff);
		rd(OFS, {ST_FIX | 16'h8000, 16'h0057});
		wr(8'h08, 4'hf, 32'hffffffff);
		rd(8'h08, 32'h00000000);
		rd(OFS, {ST_FIX | 16'h8000, 16'h0057});
		// A second reset in mid-run must clear both the enables and the flags.
		@(posedge clk);
		#1;
		reset_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		outs(8'h01);
		reset_n = 1'b1;
		rd(OFS, {ST_FIX, 16'h0000});
		results();
	end

	// Watchdog: the sequence needs well under 200 cycles, so 2000 means a hang.
	initial begin
		#(20 * 2000);
		num_errors++;
		results();
	end
endmodule
